// file: design/sbcl_bank.sv
// State sequencer of one SDRAM bank.
// Assumes the decoder only forwards commands that are legal for this bank.
`timescale 1ns/1ps
module sbcl_bank import sbcl_pkg::*; #(
	parameter int CW        = TIMER_W,
	parameter int RCD_CYC   = 2,
	parameter int RP_CYC    = 2,
	parameter int BURST_CYC = 2
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire sbcl_bank_req_t   req,
	output sbcl_bank_state_t      state
);

	sbcl_bank_state_t state_r;
	sbcl_bank_state_t state_nxt;
	logic             tmr_load;
	logic [CW-1:0]    tmr_val;
	logic             tmr_expire;

	sbcl_timer #(.W(CW)) u_tmr (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expire   (tmr_expire)
	);

	// Next state and timer load; commands take priority over a window that ends together.
	always_comb begin
		state_nxt = state_r;
		tmr_load  = 1'b0;
		tmr_val   = '0;
		if (req.pre) begin
			state_nxt = BK_PRECHARGING;
			tmr_load  = 1'b1;
			tmr_val   = CW'(RP_CYC);
		end else if (req.act) begin
			state_nxt = BK_ACTIVATING;
			tmr_load  = 1'b1;
			tmr_val   = CW'(RCD_CYC);
		end else if (req.rd || req.wr) begin
			// Auto precharge stretches the window by the recovery time.
			tmr_load  = 1'b1;
			tmr_val   = req.ap ? CW'(BURST_CYC + RP_CYC) : CW'(BURST_CYC);
			if (req.rd) begin
				state_nxt = req.ap ? BK_READ_AP : BK_READ;
			end else begin
				state_nxt = req.ap ? BK_WRITE_AP : BK_WRITE;
			end
		end else if (req.bst && state_r == BK_READ) begin
			state_nxt = BK_ACTIVE;
		end else if (tmr_expire) begin
			unique case (state_r)
				BK_ACTIVATING:  state_nxt = BK_ACTIVE;
				BK_READ:        state_nxt = BK_ACTIVE;
				BK_WRITE:       state_nxt = BK_ACTIVE;
				BK_READ_AP:     state_nxt = BK_IDLE;
				BK_WRITE_AP:    state_nxt = BK_IDLE;
				BK_PRECHARGING: state_nxt = BK_IDLE;
				BK_IDLE:        state_nxt = BK_IDLE;
				BK_ACTIVE:      state_nxt = BK_ACTIVE;
			endcase
		end
	end

	// Bank state register; without a request only an elapsed window moves it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= BK_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state = state_r;

	a_rcd_to_active: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(req.act && state_r == BK_IDLE) |=> ##RCD_CYC (state_r == BK_ACTIVE))
		else $error("Bank did not reach row active after the activate delay.");

	a_rp_to_idle: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		req.pre |=> (state_r == BK_PRECHARGING) ##RP_CYC (state_r == BK_IDLE))
		else $error("Bank did not return to idle after precharge recovery.");

	a_pre_truncates: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(state_r == BK_READ && req.pre) |=> (state_r == BK_PRECHARGING))
		else $error("Precharge did not cut the read burst short.");

	// The select bit rides along on every cycle, so only the command strobes count here.
	a_nop_holds: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(!(req.act || req.rd || req.wr || req.pre || req.bst) &&
		 state_r inside {BK_IDLE, BK_ACTIVE}) |=> $stable(state_r))
		else $error("Idle or row active bank changed state without a command.");

endmodule : sbcl_bank

// file: design/sbcl_legality.sv
// Top of the same-bank command legality block: decodes the command pins, judges each
// command against the addressed bank or the device-wide state, and sequences the banks.
// Assumes pins are synchronous to core_clk and driven by an external memory controller.
//
// Behaviour
// - Decode command from four active-low strobes.
// - Deselect or NOP leaves operations unchanged.
// - Judge command against addressed bank's state.
// - Idle after precharge recovery; accepts activate.
// - Row active after activate delay; accepts access.
// - Read state until burst ends or cut.
// - Precharge during read truncates and precharges.
// - Burst terminate ends the latest read.
// - Write state until burst ends or cut.
// - Precharging bank idles after recovery time.
// - Activating bank goes active after delay.
// - Auto-precharge access busy until recovery completes.
// - Refresh and mode load end all idle.
// - Precharge-all idles every bank after recovery.
// - Access entries include both variants; others illegal.
// - Select bit high enables auto precharge.
// - Select bit high on precharge means all.
`timescale 1ns/1ps
module sbcl_legality import sbcl_pkg::*; #(
	parameter int NB        = NUM_BANKS,
	parameter int BW        = BANK_W,
	parameter int CW        = TIMER_W,
	parameter int BL        = BURST_LEN,
	parameter int RP_CYC    = sbcl_min_cycles(PRECHARGE_RECOVERY_TIME_NS),
	parameter int RCD_CYC   = sbcl_min_cycles(ACTIVATE_TO_ACCESS_DELAY_NS),
	parameter int RFC_CYC   = sbcl_min_cycles(REFRESH_CYCLE_TIME_NS),
	parameter int MRD_CYC   = sbcl_min_cycles(MODE_REGISTER_DELAY_NS)
) (
	input  wire logic                     core_clk,
	input  wire logic                     arst_n,
	input  wire logic                     cke,
	input  wire logic                     cs_n,
	input  wire logic                     ras_n,
	input  wire logic                     cas_n,
	input  wire logic                     we_n,
	input  wire logic [BW-1:0]            bank_select,
	input  wire logic                     auto_precharge_select,
	output sbcl_bank_state_t [NB-1:0]     bank_state,
	output sbcl_glob_state_t              glob_state,
	output logic                          all_banks_idle,
	output logic                          cmd_accepted,
	output logic                          cmd_illegal,
	output sbcl_cmd_t                     last_cmd
);

	localparam int BURST_CYC = BL / BEATS_PER_CYC;

	sbcl_cmd_t                 cmd;
	sbcl_bank_state_t          tgt_state;
	sbcl_bank_req_t [NB-1:0]   bank_req;
	sbcl_glob_state_t          glob_r;
	sbcl_glob_state_t          glob_nxt;
	logic                      cke_prev_r;
	logic [BW-1:0]             last_rd_bank_r;
	logic                      last_rd_valid_r;
	logic                      exec;
	logic                      legal;
	logic                      all_idle;
	logic                      pre_all_ok;
	logic                      gtmr_load;
	logic [CW-1:0]             gtmr_val;
	logic                      gtmr_expire;
	logic                      accepted_r;
	logic                      illegal_r;
	sbcl_cmd_t                 last_cmd_r;

	// Command decode; chip select high is a deselect, treated exactly like NOP.
	always_comb begin
		cmd.bank = bank_select;
		cmd.ap   = auto_precharge_select;
		cmd.code = CMD_NOP;
		if (!cs_n) begin
			unique case ({ras_n, cas_n, we_n})
				3'h7: cmd.code = CMD_NOP;
				3'h3: cmd.code = CMD_ACT;
				3'h1: cmd.code = CMD_REF;
				3'h0: cmd.code = CMD_LMR;
				3'h5: cmd.code = CMD_RD;
				3'h4: cmd.code = CMD_WR;
				3'h2: cmd.code = CMD_PRE;
				3'h6: cmd.code = CMD_BST;
			endcase
		end
	end

	assign exec      = (cmd.code != CMD_NOP);
	assign tgt_state = bank_state[cmd.bank];

	// Whole-device conditions used by the global commands.
	always_comb begin
		all_idle   = 1'b1;
		pre_all_ok = 1'b1;
		for (int b = 0; b < NB; b++) begin
			if (bank_state[b] != BK_IDLE) begin
				all_idle = 1'b0;
			end
			// Transitional banks cannot be precharged as part of a group.
			if (bank_state[b] inside {BK_ACTIVATING, BK_READ_AP, BK_WRITE_AP,
			                          BK_PRECHARGING}) begin
				pre_all_ok = 1'b0;
			end
		end
	end

	// Legality table. Read and write entries cover both auto-precharge variants,
	// and anything not listed falls through as illegal.
	always_comb begin
		legal = 1'b0;
		if (!exec) begin
			legal = 1'b1;
		end else if (!(cke && cke_prev_r)) begin
			legal = 1'b0;
		end else if (glob_r != GL_NORMAL) begin
			legal = 1'b0;
		end else begin
			unique case (cmd.code)
				CMD_ACT: legal = (tgt_state == BK_IDLE);
				CMD_REF: legal = all_idle;
				CMD_LMR: legal = all_idle;
				CMD_RD:  legal = tgt_state inside {BK_ACTIVE, BK_READ, BK_WRITE};
				CMD_WR:  legal = tgt_state inside {BK_ACTIVE, BK_READ, BK_WRITE};
				// Precharging an idle bank is accepted as a harmless restart of precharge_recovery_time.
				CMD_PRE: legal = cmd.ap ? pre_all_ok :
				                 (tgt_state inside {BK_IDLE, BK_ACTIVE, BK_READ, BK_WRITE});
				// Terminate follows the latest read, not the bank pins.
				CMD_BST: legal = last_rd_valid_r &&
				                 (bank_state[last_rd_bank_r] == BK_READ);
				CMD_NOP: legal = 1'b1;
			endcase
		end
	end

	// Per-bank strobes; busy banks never see a command because illegal ones are dropped.
	always_comb begin
		for (int b = 0; b < NB; b++) begin
			bank_req[b]     = '0;
			bank_req[b].ap  = cmd.ap;
			if (legal && exec) begin
				bank_req[b].act = (cmd.code == CMD_ACT) && (cmd.bank == BW'(b));
				bank_req[b].rd  = (cmd.code == CMD_RD)  && (cmd.bank == BW'(b));
				bank_req[b].wr  = (cmd.code == CMD_WR)  && (cmd.bank == BW'(b));
				// Select bit high widens precharge to every bank.
				bank_req[b].pre = (cmd.code == CMD_PRE) &&
				                  (cmd.ap || (cmd.bank == BW'(b)));
				bank_req[b].bst = (cmd.code == CMD_BST) && (last_rd_bank_r == BW'(b));
			end
		end
	end

	// One sequencer per bank; each keeps its own state.
	for (genvar g = 0; g < NB; g++) begin : g_bank
		sbcl_bank #(
			.CW        (CW),
			.RCD_CYC   (RCD_CYC),
			.RP_CYC    (RP_CYC),
			.BURST_CYC (BURST_CYC)
		) u_bank (
			.core_clk (core_clk),
			.arst_n   (arst_n),
			.req      (bank_req[g]),
			.state    (bank_state[g])
		);
	end

	sbcl_timer #(.W(CW)) u_glob_tmr (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (gtmr_load),
		.load_val (gtmr_val),
		.expire   (gtmr_expire)
	);

	// Device-wide window; while it runs every executable command is refused.
	always_comb begin
		glob_nxt  = glob_r;
		gtmr_load = 1'b0;
		gtmr_val  = '0;
		if (legal && cmd.code == CMD_REF) begin
			glob_nxt  = GL_REFRESH;
			gtmr_load = 1'b1;
			gtmr_val  = CW'(RFC_CYC);
		end else if (legal && cmd.code == CMD_LMR) begin
			glob_nxt  = GL_MODE;
			gtmr_load = 1'b1;
			gtmr_val  = CW'(MRD_CYC);
		end else if (legal && cmd.code == CMD_PRE && cmd.ap) begin
			glob_nxt  = GL_PREALL;
			gtmr_load = 1'b1;
			gtmr_val  = CW'(RP_CYC);
		end else if (gtmr_expire) begin
			glob_nxt  = GL_NORMAL;
		end
	end

	// Global state register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			glob_r <= GL_NORMAL;
		end else begin
			glob_r <= glob_nxt;
		end
	end

	// Clock-enable history for the two-edge high check; assumed high out of reset.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cke_prev_r <= 1'b1;
		end else begin
			cke_prev_r <= cke;
		end
	end

	// Bank of the most recent accepted read, the target of burst terminate.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_rd_bank_r  <= '0;
			last_rd_valid_r <= 1'b0;
		end else if (legal && cmd.code == CMD_RD) begin
			last_rd_bank_r  <= cmd.bank;
			last_rd_valid_r <= 1'b1;
		end
	end

	// Verdict of each cycle, reported one cycle later from flops.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			accepted_r <= 1'b0;
			illegal_r  <= 1'b0;
			last_cmd_r <= '0;
		end else begin
			accepted_r <= exec && legal;
			illegal_r  <= exec && !legal;
			if (exec) begin
				last_cmd_r <= cmd;
			end
		end
	end

	assign glob_state     = glob_r;
	assign all_banks_idle = all_idle && (glob_r == GL_NORMAL);
	assign cmd_accepted   = accepted_r;
	assign cmd_illegal    = illegal_r;
	assign last_cmd       = last_cmd_r;

	a_decode_nop: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		cs_n |=> !cmd_accepted && !cmd_illegal)
		else $error("Deselect produced a verdict.");

	a_busy_blocks: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(glob_r != GL_NORMAL && exec) |=> cmd_illegal)
		else $error("Executable command during a global window was not flagged.");

	a_refresh_window: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(cmd.code == CMD_REF && legal) |=> (glob_r == GL_REFRESH) ##RFC_CYC
		(glob_r == GL_NORMAL))
		else $error("Refresh window did not close after the refresh cycle time.");

	a_refresh_idle: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(cmd.code inside {CMD_REF, CMD_LMR} && !all_idle && glob_r == GL_NORMAL)
		|=> cmd_illegal && glob_r == GL_NORMAL)
		else $error("Refresh or mode load with a busy bank was accepted.");

	a_cke_low_flag: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(!cke && exec) |=> cmd_illegal && !cmd_accepted)
		else $error("Command with clock-enable low was not flagged.");

	a_busy_bank_cmd: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(exec && cmd.code != CMD_BST && tgt_state == BK_ACTIVATING && !cmd.ap)
		|=> cmd_illegal)
		else $error("Command to an activating bank was not flagged.");

	a_preall_idles: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(cmd.code == CMD_PRE && cmd.ap && legal) |=> ##RP_CYC all_banks_idle)
		else $error("Banks not idle after precharge-all recovery.");

endmodule : sbcl_legality

// file: design/sbcl_pkg.sv
// Package for the same-bank command legality block of a DDR SDRAM.
// Assumes a single 100 MHz core clock; every figure used by the logic is named here.
package sbcl_pkg;

	// Clock period in picoseconds, the base for every time-to-cycle conversion.
	localparam int CLK_PERIOD_PS = 10000;
	localparam int PS_PER_NS     = 1000;

	// Least times in nanoseconds; plain defaults, tune per speed grade.
	localparam int PRECHARGE_RECOVERY_TIME_NS  = 20;
	localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS       = 80;
	localparam int MODE_REGISTER_DELAY_NS      = 20;

	// Burst length in beats; two beats pass per clock cycle.
	localparam int BURST_LEN      = 4;
	localparam int BEATS_PER_CYC  = 2;
	localparam int NUM_BANKS      = 4;
	localparam int BANK_W         = 2;
	localparam int TIMER_W        = 8;

	// A least time rounds up to whole cycles and never comes to less than one.
	function automatic int sbcl_min_cycles(input int time_ns);
		int cyc;
		cyc = (time_ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (cyc < 1) ? 1 : cyc;
	endfunction : sbcl_min_cycles

	// Commands decoded from the strobes; deselect folds into the no-operation code.
	typedef enum logic [2:0] {
		CMD_NOP   = 3'h0,
		CMD_ACT   = 3'h1,
		CMD_RD    = 3'h2,
		CMD_WR    = 3'h3,
		CMD_PRE   = 3'h4,
		CMD_BST   = 3'h5,
		CMD_REF   = 3'h6,
		CMD_LMR   = 3'h7
	} sbcl_cmd_code_t;

	// Per-bank states.
	typedef enum logic [2:0] {
		BK_IDLE       = 3'h0,
		BK_ACTIVATING = 3'h1,
		BK_ACTIVE     = 3'h2,
		BK_READ       = 3'h3,
		BK_WRITE      = 3'h4,
		BK_READ_AP    = 3'h5,
		BK_WRITE_AP   = 3'h6,
		BK_PRECHARGING = 3'h7
	} sbcl_bank_state_t;

	// Device-wide states; every state but GL_NORMAL is a window that no executable command may interrupt.
	typedef enum logic [1:0] {
		GL_NORMAL  = 2'h0,
		GL_REFRESH = 2'h1,
		GL_MODE    = 2'h2,
		GL_PREALL  = 2'h3
	} sbcl_glob_state_t;

	// A decoded command with its address qualifiers.
	typedef struct packed {
		sbcl_cmd_code_t    code;
		logic [BANK_W-1:0] bank;
		logic              ap;
	} sbcl_cmd_t;

	// Strobes that the decoder hands to one bank; only legal commands arrive.
	typedef struct packed {
		logic act;
		logic rd;
		logic wr;
		logic pre;
		logic bst;
		logic ap;
	} sbcl_bank_req_t;

endpackage : sbcl_pkg

// file: design/sbcl_timer.sv
// Down-counter used for every recovery and delay window of the block.
// Assumes the loaded value is at least one; expire pulses in the last counted cycle.
`timescale 1ns/1ps
module sbcl_timer import sbcl_pkg::*; #(
	parameter int W = TIMER_W
) (
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expire
);

	logic [W-1:0] cnt_r;

	// A load restarts the window even if one is running, so a new burst extends it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	// Expiry is suppressed by a same-cycle load so the reloaded window wins.
	assign expire = (cnt_r == W'(1)) && !load;

endmodule : sbcl_timer

// file: verif/sbcl_ctrl_model.sv
// Behavioural memory controller that drives SDRAM command pins of the legality block.
// Assumes every task is entered at a falling clock edge, so pins change away from sampling.
`timescale 1ns/1ps
module sbcl_ctrl_model import sbcl_pkg::*; (
	input  wire logic          core_clk,
	output logic               cke,
	output logic               cs_n,
	output logic               ras_n,
	output logic               cas_n,
	output logic               we_n,
	output logic [BANK_W-1:0]  bank_select,
	output logic               auto_precharge_select
);
	// Strobe pattern {row, column, write}, all active low, for each command code.
	function automatic logic [2:0] enc(input sbcl_cmd_code_t c);
		case (c)
			CMD_ACT: return 3'h3;
			CMD_RD:  return 3'h5;
			CMD_WR:  return 3'h4;
			CMD_PRE: return 3'h2;
			CMD_BST: return 3'h6;
			CMD_REF: return 3'h1;
			CMD_LMR: return 3'h0;
			default: return 3'h7;
		endcase
	endfunction : enc

	// Clock enable stays high unless a scenario lowers it on purpose.
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		bank_select = '0;
		auto_precharge_select = 1'b0;
	end

	// One command for one edge; a high desel turns it into a deselect.
	// No data lanes exist here, so no data_mask is driven; scenarios never cut a
	// write burst with a read or precharge to the same bank.
	task automatic cmd(input sbcl_cmd_code_t c, input logic [BANK_W-1:0] b, input logic ap,
			input logic desel);
		cs_n = desel;
		{ras_n, cas_n, we_n} = enc(c);
		bank_select = b;
		auto_precharge_select = ap;
		@(negedge core_clk);
	endtask : cmd

	// No-operation cycles; unused address lines toggle so nothing leans on a stale value.
	task automatic idle(input int n);
		repeat (n) begin
			cs_n = 1'b0;
			{ras_n, cas_n, we_n} = 3'h7;
			bank_select = ~bank_select;
			auto_precharge_select = ~auto_precharge_select;
			@(negedge core_clk);
		end
	endtask : idle

	// Clock-enable level for the following edges.
	task automatic set_cke(input logic v);
		cke = v;
	endtask : set_cke
endmodule : sbcl_ctrl_model

// file: verif/testbench.sv
// Self-checking bench for the same-bank command legality block.
// Assumes default design counts: precharge 2, activate 2, refresh 8, mode 2, burst 2 cycles.
`timescale 1ns/1ps
module testbench import sbcl_pkg::*;;
	logic                              core_clk;
	logic                              arst_n;
	logic                              cke;
	logic                              cs_n;
	logic                              ras_n;
	logic                              cas_n;
	logic                              we_n;
	logic [BANK_W-1:0]                 bank_select;
	logic                              auto_precharge_select;
	sbcl_bank_state_t [NUM_BANKS-1:0]  bank_state;
	sbcl_glob_state_t                  glob_state;
	logic                              all_banks_idle;
	logic                              cmd_accepted;
	logic                              cmd_illegal;
	sbcl_cmd_t                         last_cmd;
	int                                miscompares;
	int                                n_checks;
	int                                cyc;

	sbcl_legality sbcl_legality_i (.core_clk(core_clk), .arst_n(arst_n), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
		.auto_precharge_select(auto_precharge_select), .bank_state(bank_state),
		.glob_state(glob_state), .all_banks_idle(all_banks_idle),
		.cmd_accepted(cmd_accepted), .cmd_illegal(cmd_illegal), .last_cmd(last_cmd));

	sbcl_ctrl_model sbcl_ctrl_model_i (.core_clk(core_clk), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
		.auto_precharge_select(auto_precharge_select));

	// Free-running 100 MHz clock.
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// Hang guard; the whole run needs well under a hundred cycles.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// Compare tasks, one for each kind of result.
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_st(input sbcl_bank_state_t got, input sbcl_bank_state_t exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_st

	task automatic chk_gl(input sbcl_glob_state_t got, input sbcl_glob_state_t exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_gl

	task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_vec

	// Shorthands for the command driver.
	task automatic cm(input sbcl_cmd_code_t c, input logic [1:0] b, input logic ap);
		sbcl_ctrl_model_i.cmd(c, b, ap, 1'b0);
	endtask : cm

	task automatic nop(input int n);
		sbcl_ctrl_model_i.idle(n);
	endtask : nop

	// Answer pulses seen in the cycle after a command edge.
	task automatic pulses(input logic acc, input logic ill);
		chk_bit(cmd_accepted, acc);
		chk_bit(cmd_illegal, ill);
	endtask : pulses

	// Activation holds for the activate delay and reaches row active.
	task automatic t_activate();
		cm(CMD_ACT, 2'h0, 1'b0);
		pulses(1'b1, 1'b0);
		chk_st(bank_state[0], BK_ACTIVATING);
		chk_st(bank_state[1], BK_IDLE);
		nop(1);
		chk_st(bank_state[0], BK_ACTIVATING);
		// A read into the activating window on purpose: refused, the window still ends.
		cm(CMD_RD, 2'h0, 1'b0);
		pulses(1'b0, 1'b1);
		chk_st(bank_state[0], BK_ACTIVE);
	endtask : t_activate

	// Read restart, burst terminate of the latest read, and a stray terminate.
	task automatic t_read_bst();
		cm(CMD_RD, 2'h0, 1'b0);
		chk_st(bank_state[0], BK_READ);
		cm(CMD_RD, 2'h0, 1'b0);
		pulses(1'b1, 1'b0);
		nop(1);
		chk_st(bank_state[0], BK_READ);
		// Fresh burst, then terminate on the next edge, one cycle before it would end by itself.
		cm(CMD_RD, 2'h0, 1'b0);
		cm(CMD_BST, 2'h2, 1'b0);
		pulses(1'b1, 1'b0);
		chk_st(bank_state[0], BK_ACTIVE);
		cm(CMD_BST, 2'h0, 1'b0);
		pulses(1'b0, 1'b1);
		chk_vec({2'h0, last_cmd}, {2'h0, CMD_BST, 2'h0, 1'b0});
	endtask : t_read_bst

	// Precharge cuts a read; the bank idles after recovery and refuses a read then.
	task automatic t_read_pre();
		cm(CMD_RD, 2'h0, 1'b0);
		cm(CMD_PRE, 2'h0, 1'b0);
		pulses(1'b1, 1'b0);
		chk_st(bank_state[0], BK_PRECHARGING);
		nop(1);
		chk_st(bank_state[0], BK_PRECHARGING);
		nop(1);
		chk_st(bank_state[0], BK_IDLE);
		cm(CMD_RD, 2'h0, 1'b0);
		pulses(1'b0, 1'b1);
		chk_st(bank_state[0], BK_IDLE);
	endtask : t_read_pre

	// Plain write burst, then write with auto precharge back to idle.
	task automatic t_write();
		cm(CMD_ACT, 2'h1, 1'b0);
		nop(2);
		cm(CMD_WR, 2'h1, 1'b0);
		chk_st(bank_state[1], BK_WRITE);
		nop(2);
		chk_st(bank_state[1], BK_ACTIVE);
		cm(CMD_WR, 2'h1, 1'b1);
		chk_st(bank_state[1], BK_WRITE_AP);
		nop(3);
		chk_st(bank_state[1], BK_WRITE_AP);
		nop(1);
		chk_st(bank_state[1], BK_IDLE);
	endtask : t_write

	// Refresh locks out commands until its window ends; mode load then runs its own window.
	task automatic t_global();
		cm(CMD_REF, 2'h0, 1'b0);
		chk_gl(glob_state, GL_REFRESH);
		chk_bit(all_banks_idle, 1'b0);
		cm(CMD_ACT, 2'h2, 1'b0);
		pulses(1'b0, 1'b1);
		nop(6);
		chk_gl(glob_state, GL_REFRESH);
		nop(1);
		chk_gl(glob_state, GL_NORMAL);
		chk_st(bank_state[2], BK_IDLE);
		cm(CMD_LMR, 2'h0, 1'b0);
		chk_gl(glob_state, GL_MODE);
		nop(1);
		chk_gl(glob_state, GL_MODE);
		nop(1);
		chk_bit(all_banks_idle, 1'b1);
	endtask : t_global

	// Refresh refused with an open row; precharge-all ignores the bank lines.
	task automatic t_preall();
		int i;
		cm(CMD_ACT, 2'h2, 1'b0);
		nop(2);
		cm(CMD_REF, 2'h0, 1'b0);
		pulses(1'b0, 1'b1);
		cm(CMD_PRE, 2'h0, 1'b1);
		chk_gl(glob_state, GL_PREALL);
		for (i = 0; i < NUM_BANKS; i++)
			chk_st(bank_state[i], BK_PRECHARGING);
		nop(2);
		for (i = 0; i < NUM_BANKS; i++)
			chk_st(bank_state[i], BK_IDLE);
		chk_gl(glob_state, GL_NORMAL);
	endtask : t_preall

	// Clock enable low now or at the previous edge refuses commands.
	task automatic t_cke();
		sbcl_ctrl_model_i.set_cke(1'b0);
		cm(CMD_ACT, 2'h3, 1'b0);
		pulses(1'b0, 1'b1);
		sbcl_ctrl_model_i.set_cke(1'b1);
		cm(CMD_ACT, 2'h3, 1'b0);
		pulses(1'b0, 1'b1);
		chk_st(bank_state[3], BK_IDLE);
		cm(CMD_ACT, 2'h3, 1'b0);
		pulses(1'b1, 1'b0);
		nop(2);
		cm(CMD_PRE, 2'h3, 1'b0);
		nop(2);
	endtask : t_cke

	// Deselect carrying an activate pattern starts nothing and is not recorded.
	task automatic t_deselect();
		sbcl_ctrl_model_i.cmd(CMD_ACT, 2'h0, 1'b0, 1'b1);
		pulses(1'b0, 1'b0);
		chk_st(bank_state[0], BK_IDLE);
		chk_vec({2'h0, last_cmd}, {2'h0, CMD_PRE, 2'h3, 1'b0});
	endtask : t_deselect

	// Reset for six cycles, release off the edge, then run every scenario.
	initial begin
		miscompares = 0;
		n_checks = 0;
		cyc = 0;
		arst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		chk_bit(all_banks_idle, 1'b1);
		chk_gl(glob_state, GL_NORMAL);
		arst_n = 1'b1;
		t_activate();
		t_read_bst();
		t_read_pre();
		t_write();
		t_global();
		t_preall();
		t_cke();
		t_deselect();
		final_report();
	end
endmodule : testbench
